// ===== lcs_pkg.sv
// Constants, field positions and state type of the character display sequencer
package lcs_pkg;

  // ****************************************************
  // Display and glyph memory layout
  // ****************************************************
  localparam int         DD_ROW_LEN = 40;
  localparam int         DD_SIZE    = 80;
  localparam int         CG_SIZE    = 64;
  localparam logic [6:0] ROW1_BASE  = 7'h40;
  localparam logic [6:0] ROW0_LAST  = 7'h27;
  localparam logic [6:0] ROW1_LAST  = 7'h67;
  localparam logic [5:0] OFF_LAST   = 6'h27;
  localparam logic [7:0] BLANK_CHAR = 8'h20;

  // ****************************************************
  // Instruction field positions and busy flag value
  // ****************************************************
  localparam int ENT_INC_BIT    = 1;
  localparam int ENT_SHIFT_BIT  = 0;
  localparam int DISP_ON_BIT    = 2;
  localparam int DISP_CUR_BIT   = 1;
  localparam int DISP_BLINK_BIT = 0;
  localparam int SH_DISP_BIT    = 3;
  localparam int SH_RIGHT_BIT   = 2;
  localparam int FN_BUS8_BIT    = 4;
  localparam int FN_TWO_BIT     = 3;
  localparam int FN_FONT_BIT    = 2;
  localparam logic BUSY_FLAG    = 1'b0;

  // ****************************************************
  // Reset values
  // ****************************************************
  localparam logic RST_BUS8    = 1'b1;
  localparam logic RST_DISP_ON = 1'b0;
  localparam logic RST_INC     = 1'b1;

  typedef struct packed {
    logic [DD_SIZE-1:0][7:0] dd;
    logic [CG_SIZE-1:0][7:0] cg;
    logic [6:0]              ac;
    logic                    sel_cg;
    logic                    inc;
    logic                    ent_shift;
    logic                    disp_on;
    logic                    cur_on;
    logic                    blink;
    logic                    bus8;
    logic                    two_line;
    logic                    font;
    logic [5:0]              offset;
    logic                    phase;
    logic [3:0]              hi_nib;
    logic [7:0]              rd_byte;
    logic [7:0]              out_q;
    logic [7:0]              view_q;
  } lcs_state_t;

endpackage

// ===== lcs_sequencer.sv
// Instruction interpreter of the character display controller
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps

module lcs_sequencer
  import lcs_pkg::*;
(
  input  wire logic       ref_clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       reg_select_in,
  input  wire logic       bus_wr_in,
  input  wire logic       bus_rd_in,
  input  wire logic [7:0] bus_data_in,
  output logic      [7:0] bus_data_out,
  output logic            display_on_out,
  output logic            cursor_on_out,
  output logic            blink_out,
  output logic            two_line_out,
  output logic            font_large_out,
  output logic            bus8_out,
  output logic            glyph_sel_out,
  output logic      [6:0] addr_counter_out,
  output logic      [5:0] shift_offset_out,
  input  wire logic       view_row_in,
  input  wire logic [5:0] view_col_in,
  output logic      [7:0] view_char_out
);

  // ****************************************************
  // Helpers
  // ****************************************************
  function automatic logic [6:0] dd_index(input logic [6:0] a);
    logic [6:0] col;
    col = {1'b0, a[5:0]};
    return a[6] ? 7'(col + 7'(DD_ROW_LEN)) : col;
  endfunction

  function automatic logic [6:0] ac_step(input logic [6:0] a, input logic up,
                                         input logic cg);
    logic [6:0] r;
    r = up ? 7'(a + 7'h01) : 7'(a - 7'h01);
    if (cg)
      r = {1'b0, r[5:0]};
    else if (up && a == ROW0_LAST)
      r = ROW1_BASE;
    else if (up && a == ROW1_LAST)
      r = 7'h00;
    else if (!up && a == 7'h00)
      r = ROW1_LAST;
    else if (!up && a == ROW1_BASE)
      r = ROW0_LAST;
    return r;
  endfunction

  // Single offset for both rows, so rows can never drift apart
  function automatic logic [5:0] off_step(input logic [5:0] o, input logic up);
    if (up)
      return (o == OFF_LAST) ? 6'h00 : 6'(o + 6'h01);
    return (o == 6'h00) ? OFF_LAST : 6'(o - 6'h01);
  endfunction

  // ****************************************************
  // State
  // ****************************************************
  lcs_state_t st_ff;
  lcs_state_t nxt_st;
  logic [7:0] byte_v;
  logic       go_wr;
  logic       go_rd;
  logic       instr_go;
  logic       data_go;
  logic       dd_ok;
  logic [6:0] ac_idx;
  logic [6:0] vcol;
  logic [7:0] rbyte;

  assign byte_v   = st_ff.bus8 ? bus_data_in : {st_ff.hi_nib, bus_data_in[7:4]};
  assign go_wr    = bus_wr_in & (st_ff.bus8 | st_ff.phase);
  assign go_rd    = bus_rd_in & (st_ff.bus8 | st_ff.phase);
  assign instr_go = go_wr & ~reg_select_in;
  assign data_go  = go_wr & reg_select_in;
  assign dd_ok    = st_ff.ac[5:0] < 6'(DD_ROW_LEN);
  assign ac_idx   = dd_index(st_ff.ac);
  assign vcol     = 7'({1'b0, view_col_in} + {1'b0, st_ff.offset});

  always_comb
  begin
    nxt_st = st_ff;
    rbyte  = {BUSY_FLAG, st_ff.ac};
    if (reg_select_in)
      rbyte = st_ff.sel_cg ? st_ff.cg[st_ff.ac[5:0]] :
              (dd_ok ? st_ff.dd[ac_idx] : 8'h00);
    // Nibble phase shared by reads and writes; mixing them mid-pair is a host error
    if (!st_ff.bus8 && (bus_wr_in || bus_rd_in))
      nxt_st.phase = ~st_ff.phase;
    if (bus_wr_in && !st_ff.bus8 && !st_ff.phase)
      nxt_st.hi_nib = bus_data_in[7:4];
    if (bus_rd_in)
    begin
      if (st_ff.bus8)
        nxt_st.out_q = rbyte;
      else if (!st_ff.phase)
      begin
        nxt_st.rd_byte = rbyte;
        nxt_st.out_q   = {rbyte[7:4], 4'h0};
      end
      else
        nxt_st.out_q = {st_ff.rd_byte[3:0], 4'h0};
      if (go_rd && reg_select_in)
        nxt_st.ac = ac_step(st_ff.ac, st_ff.inc, st_ff.sel_cg);
    end
    if (data_go)
    begin
      if (st_ff.sel_cg)
        nxt_st.cg[st_ff.ac[5:0]] = byte_v;
      else if (dd_ok)
        nxt_st.dd[ac_idx] = byte_v;
      nxt_st.ac = ac_step(st_ff.ac, st_ff.inc, st_ff.sel_cg);
      if (st_ff.ent_shift && !st_ff.sel_cg)
        nxt_st.offset = off_step(st_ff.offset, st_ff.inc);
    end
    if (instr_go)
    begin
      if (byte_v[7])
      begin
        nxt_st.sel_cg = 1'b0;
        nxt_st.ac     = byte_v[6:0];
      end
      else if (byte_v[6])
      begin
        nxt_st.sel_cg = 1'b1;
        nxt_st.ac     = {1'b0, byte_v[5:0]};
      end
      else if (byte_v[5])
      begin
        nxt_st.bus8     = byte_v[FN_BUS8_BIT];
        nxt_st.two_line = byte_v[FN_TWO_BIT];
        nxt_st.font     = byte_v[FN_FONT_BIT];
        nxt_st.phase    = 1'b0;
      end
      else if (byte_v[4])
      begin
        // Cursor always moves; display follows when bit3 set
        nxt_st.ac = ac_step(st_ff.ac, byte_v[SH_RIGHT_BIT], 1'b0);
        if (byte_v[SH_DISP_BIT])
          nxt_st.offset = off_step(st_ff.offset, ~byte_v[SH_RIGHT_BIT]);
      end
      else if (byte_v[3])
      begin
        nxt_st.disp_on = byte_v[DISP_ON_BIT];
        nxt_st.cur_on  = byte_v[DISP_CUR_BIT];
        nxt_st.blink   = byte_v[DISP_BLINK_BIT];
      end
      else if (byte_v[2])
      begin
        nxt_st.inc       = byte_v[ENT_INC_BIT];
        nxt_st.ent_shift = byte_v[ENT_SHIFT_BIT];
      end
      else if (byte_v[1])
      begin
        nxt_st.ac     = 7'h00;
        nxt_st.offset = 6'h00;
        nxt_st.sel_cg = 1'b0;
      end
      else if (byte_v[0])
      begin
        for (int i = 0; i < DD_SIZE; i++)
          nxt_st.dd[i] = BLANK_CHAR;
        nxt_st.ac     = 7'h00;
        nxt_st.offset = 6'h00;
        nxt_st.sel_cg = 1'b0;
        nxt_st.inc    = 1'b1;
      end
    end
    if (vcol >= 7'(DD_ROW_LEN))
      nxt_st.view_q = st_ff.dd[dd_index({view_row_in, 6'(vcol - 7'(DD_ROW_LEN))})];
    else
      nxt_st.view_q = st_ff.dd[dd_index({view_row_in, vcol[5:0]})];
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      st_ff         <= '0;
      st_ff.bus8    <= RST_BUS8;
      st_ff.disp_on <= RST_DISP_ON;
      st_ff.inc     <= RST_INC;
    end
    else
      st_ff <= nxt_st;
  end

  assign bus_data_out     = st_ff.out_q;
  assign display_on_out   = st_ff.disp_on;
  assign cursor_on_out    = st_ff.cur_on;
  assign blink_out        = st_ff.blink;
  assign two_line_out     = st_ff.two_line;
  assign font_large_out   = st_ff.font;
  assign bus8_out         = st_ff.bus8;
  assign glyph_sel_out    = st_ff.sel_cg;
  assign addr_counter_out = st_ff.ac;
  assign shift_offset_out = st_ff.offset;
  assign view_char_out    = st_ff.view_q;

  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);

  property p_row_wrap;
    data_go && !st_ff.sel_cg && st_ff.inc && st_ff.ac == ROW0_LAST |=> st_ff.ac == ROW1_BASE;
  endproperty
  a_row_wrap: assert property (p_row_wrap) else $error("row end did not wrap");

  property p_rows_shift;
    instr_go && byte_v[7:2] == 6'b000111 && st_ff.offset == 6'h00 |=> st_ff.offset == OFF_LAST;
  endproperty
  a_rows_shift: assert property (p_rows_shift) else $error("row rotate wrong");

  property p_row2;
    instr_go && byte_v == 8'hC0 |=> st_ff.ac == ROW1_BASE && !st_ff.sel_cg;
  endproperty
  a_row2: assert property (p_row2) else $error("second row address wrong");

  property p_home;
    instr_go && byte_v[7:1] == 7'h01 |=> st_ff.ac == 7'h00 && st_ff.offset == 6'h00;
  endproperty
  a_home: assert property (p_home) else $error("home not zero");

  property p_cur_only;
    instr_go && byte_v[7:2] == 6'b000101 && st_ff.ac[5:0] < 6'h27 |=>
      st_ff.ac == 7'($past(st_ff.ac) + 7'h01) && $stable(st_ff.offset);
  endproperty
  a_cur_only: assert property (p_cur_only) else $error("cursor shift wrong");

  property p_scroll;
    data_go && st_ff.ent_shift && st_ff.inc && !st_ff.sel_cg && st_ff.offset == OFF_LAST
      |=> st_ff.offset == 6'h00;
  endproperty
  a_scroll: assert property (p_scroll) else $error("write scroll wrong");

  property p_incr;
    data_go && !st_ff.sel_cg && st_ff.inc && !st_ff.ent_shift && st_ff.ac == 7'h05
      |=> st_ff.ac == 7'h06 && $stable(st_ff.offset);
  endproperty
  a_incr: assert property (p_incr) else $error("increment wrong");

  property p_store;
    data_go && !st_ff.sel_cg && st_ff.ac == 7'h00 |=> st_ff.dd[0] == $past(byte_v);
  endproperty
  a_store: assert property (p_store) else $error("data not stored");

  property p_on_cause;
    $rose(st_ff.disp_on) |-> $past(instr_go);
  endproperty
  a_on_cause: assert property (p_on_cause) else $error("display on by itself");

  property p_disp;
    instr_go && byte_v == 8'h0E |=> display_on_out && cursor_on_out && !blink_out;
  endproperty
  a_disp: assert property (p_disp) else $error("display control wrong");

  property p_func;
    instr_go && byte_v[7:5] == 3'b001 |=>
      two_line_out == $past(byte_v[3]) && bus8_out == $past(byte_v[4]);
  endproperty
  a_func: assert property (p_func) else $error("function set wrong");

  property p_bus8;
    $fell(st_ff.bus8) |-> $past(instr_go);
  endproperty
  a_bus8: assert property (p_bus8) else $error("width left 8-bit");

  property p_nib;
    bus_wr_in && !st_ff.bus8 && !st_ff.phase |=> $stable(st_ff.ac) && st_ff.phase;
  endproperty
  a_nib: assert property (p_nib) else $error("first nibble executed");

  property p_rd4;
    bus_rd_in && !st_ff.bus8 && !st_ff.phase |=> bus_data_out[3:0] == 4'h0 && st_ff.phase;
  endproperty
  a_rd4: assert property (p_rd4) else $error("nibble read wrong");

  property p_dec;
    data_go && !st_ff.sel_cg && !st_ff.inc && st_ff.ac == ROW1_BASE |=> st_ff.ac == ROW0_LAST;
  endproperty
  a_dec: assert property (p_dec) else $error("decrement wrong");

  c_row2:   cover property (instr_go && byte_v == 8'hC0);
  c_scroll: cover property (data_go && st_ff.ent_shift);
  c_four:   cover property ($fell(st_ff.bus8) ##1 go_wr);
endmodule

// ===== lcs_host_model.sv
// Host microcontroller model driving the display bus
`timescale 1ns/1ps
module lcs_host_model
(
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  output logic            reg_select_out,
  output logic            wr_out,
  output logic            rd_out,
  output logic      [7:0] data_out
);
  logic nib_mode = 1'b0;

  initial
  begin
    reg_select_out = 1'b0;
    wr_out         = 1'b0;
    rd_out         = 1'b0;
    data_out       = 8'h5A;
  end

  // ****************************************************
  // Bus accesses
  // ****************************************************
  // Idle cycle between accesses; device never busy
  task automatic acc(input logic rs, input logic w, input logic [7:0] d);
    @(posedge clk_in);
    reg_select_out <= rs;
    wr_out         <= w;
    rd_out         <= ~w;
    data_out       <= d;
    @(posedge clk_in);
    wr_out   <= 1'b0;
    rd_out   <= 1'b0;
    data_out <= ~d;
  endtask

  // Low lines unconnected in narrow mode, so junk rides on them
  task automatic put(input logic rs, input logic [7:0] b);
    if (nib_mode)
    begin
      acc(rs, 1'b1, {b[7:4], ~b[3:0]});
      acc(rs, 1'b1, {b[3:0], b[7:4]});
    end
    else
      acc(rs, 1'b1, b);
  endtask

  task automatic get(input logic rs, output logic [7:0] v);
    logic [7:0] hi;
    acc(rs, 1'b0, data_out);
    @(negedge clk_in);
    hi = rdata_in;
    if (nib_mode)
    begin
      acc(rs, 1'b0, data_out);
      @(negedge clk_in);
      hi = {hi[7:4], rdata_in[7:4]};
    end
    v = hi;
  endtask
endmodule

// ===== lcs_sequencer_bench.sv
// Self-checking bench of the character display instruction sequencer
`timescale 1ns/1ps
module lcs_sequencer_bench;
  import lcs_pkg::*;
  logic       ref_clk_in, reset_n_in, reg_select_in, bus_wr_in, bus_rd_in;
  logic       view_row_in, display_on_out, cursor_on_out, blink_out;
  logic       two_line_out, font_large_out, bus8_out, glyph_sel_out, up, shf;
  logic [7:0] bus_data_in, bus_data_out, view_char_out, rb, gv;
  logic [6:0] addr_counter_out, ac;
  logic [5:0] view_col_in, shift_offset_out;
  logic [7:0] exp_dd [2][40];
  int         off, mismatches, num_checks, seed;
  localparam logic [7:0] SHIFT_OPS [4] = '{8'h10, 8'h14, 8'h18, 8'h1C};

  lcs_sequencer u_lcs_sequencer (.ref_clk_in, .reset_n_in, .reg_select_in, .bus_wr_in,
    .bus_rd_in, .bus_data_in, .bus_data_out, .display_on_out, .cursor_on_out, .blink_out,
    .two_line_out, .font_large_out, .bus8_out, .glyph_sel_out, .addr_counter_out,
    .shift_offset_out, .view_row_in, .view_col_in, .view_char_out);

  lcs_host_model u_lcs_host_model (.clk_in(ref_clk_in), .rdata_in(bus_data_out),
    .reg_select_out(reg_select_in), .wr_out(bus_wr_in), .rd_out(bus_rd_in),
    .data_out(bus_data_in));

  // ****************************************************
  // Expectation and compare helpers
  // ****************************************************
  function automatic logic [6:0] step(input logic [6:0] a, input logic inc);
    if (inc)
      return (a == ROW0_LAST) ? ROW1_BASE : (a == ROW1_LAST) ? 7'h00 : a + 7'h01;
    return (a == 7'h00) ? ROW1_LAST : (a == ROW1_BASE) ? ROW0_LAST : a - 7'h01;
  endfunction

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      $display("BAD %s exp %h got %h", n, e, g);
      mismatches++;
    end
  endtask

  task automatic st;
    chk("ac", {1'b0, ac}, {1'b0, addr_counter_out});
    chk("offset", 8'(off), {2'h0, shift_offset_out});
  endtask

  task automatic instr(input logic [7:0] b);
    u_lcs_host_model.put(1'b0, b);
    @(negedge ref_clk_in);
  endtask

  task automatic wdata(input logic [7:0] b);
    u_lcs_host_model.put(1'b1, b);
    exp_dd[ac[6]][ac[5:0]] = b;
    ac = step(ac, up);
    if (shf)
      off = (off + 1) % 40;
    @(negedge ref_clk_in);
    st();
  endtask

  // Offset applies to both rows alike
  task automatic vchk(input logic r, input int c);
    @(posedge ref_clk_in);
    view_row_in <= r;
    view_col_in <= 6'(c);
    @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    chk("view", exp_dd[r][(c + off) % 40], view_char_out);
  endtask

  task automatic finish_test;
    if (mismatches == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ****************************************************
  // Clock, watchdog and main sequence
  // ****************************************************
  initial
  begin
    ref_clk_in = 1'b0;
    forever #4 ref_clk_in = ~ref_clk_in;
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk_in);
    mismatches++;
    finish_test();
  end

  initial
  begin
    seed = 32'hCC96;
    reset_n_in = 1'b0;
    view_row_in = 1'b0;
    view_col_in = 6'h00;
    exp_dd = '{default: 8'h00};
    {ac, off, up, shf} = '0;
    up = 1'b1;
    repeat (20) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    @(negedge ref_clk_in);
    chk("disp", 8'h00, {7'h00, display_on_out});
    chk("bus8", 8'h01, {7'h00, bus8_out});
    chk("glyph", 8'h00, {7'h00, glyph_sel_out});
    instr(8'h38);
    chk("lines", 8'h03, {6'h00, two_line_out, bus8_out});
    chk("font", 8'h00, {7'h00, font_large_out});
    instr(8'h0E);
    chk("dctl", 8'h06, {5'h00, display_on_out, cursor_on_out, blink_out});
    instr(8'h06);
    repeat (8) wdata(8'($random(seed)));
    instr(8'hC0);
    ac = ROW1_BASE;
    st();
    repeat (8) wdata(8'($random(seed)));
    instr(8'h07);
    shf = 1'b1;
    repeat (3) wdata(8'($random(seed)));
    for (int c = 0; c < 8; c++)
    begin
      vchk(1'b0, c);
      vchk(1'b1, c);
    end
    foreach (SHIFT_OPS[i])
    begin
      instr(SHIFT_OPS[i]);
      // Cursor moves on every shift, display only when bit3 set
      ac = step(ac, SHIFT_OPS[i][2]);
      chk("ac", {1'b0, ac}, {1'b0, addr_counter_out});
      if (SHIFT_OPS[i][3])
        off = SHIFT_OPS[i][2] ? (off + 39) % 40 : (off + 1) % 40;
      chk("offset", 8'(off), {2'h0, shift_offset_out});
    end
    instr(8'h02);
    {ac, off} = '0;
    st();
    instr(8'h1C);
    off = 39;
    ac = step(ac, 1'b1);
    vchk(1'b1, 0);
    instr(8'h07);
    shf = 1'b1;
    wdata(8'($random(seed)));
    instr(8'h02);
    instr(8'h04);
    {ac, off, shf, up} = '0;
    wdata(8'($random(seed)));
    u_lcs_host_model.get(1'b0, rb);
    chk("status", {BUSY_FLAG, ac}, rb);
    instr(8'hC0);
    ac = ROW1_BASE;
    wdata(8'($random(seed)));
    instr(8'h06);
    up = 1'b1;
    wdata(8'($random(seed)));
    instr(8'h45);
    chk("glyph", 8'h01, {7'h00, glyph_sel_out});
    gv = 8'($random(seed));
    u_lcs_host_model.put(1'b1, gv);
    instr(8'h45);
    u_lcs_host_model.get(1'b1, rb);
    chk("gread", gv, rb);
    chk("ac", 8'h06, {1'b0, addr_counter_out});
    vchk(1'b0, 5);
    instr(8'h01);
    exp_dd = '{default: BLANK_CHAR};
    {ac, off} = '0;
    st();
    chk("glyph", 8'h00, {7'h00, glyph_sel_out});
    vchk(1'b1, 3);
    // Low lines float on the wide access, so only width is checked
    u_lcs_host_model.acc(1'b0, 1'b1, {4'h2, 4'($random(seed))});
    @(negedge ref_clk_in);
    chk("bus8", 8'h00, {7'h00, bus8_out});
    u_lcs_host_model.nib_mode = 1'b1;
    instr(8'h28);
    chk("lines", 8'h02, {6'h00, two_line_out, bus8_out});
    chk("font", 8'h00, {7'h00, font_large_out});
    instr(8'h2C);
    chk("font", 8'h01, {7'h00, font_large_out});
    u_lcs_host_model.acc(1'b0, 1'b1, 8'h0F);
    @(negedge ref_clk_in);
    chk("half", 8'h01, {7'h00, cursor_on_out});
    u_lcs_host_model.acc(1'b0, 1'b1, 8'hC0);
    @(negedge ref_clk_in);
    chk("dctl", 8'h04, {5'h00, display_on_out, cursor_on_out, blink_out});
    u_lcs_host_model.get(1'b0, rb);
    chk("status", {BUSY_FLAG, ac}, rb);
    instr(8'h06);
    up = 1'b1;
    instr(8'h80);
    ac = 7'h00;
    wdata(8'($random(seed)));
    instr(8'h80);
    ac = 7'h00;
    u_lcs_host_model.get(1'b1, rb);
    chk("dread", exp_dd[0][0], rb);
    ac = step(ac, up);
    st();
    vchk(1'b0, 0);
    finish_test();
  end
endmodule
